// [shared/dcm_pkg.sv]
// constants and types for the dac core mode, clock trim and shuffle control
package dcm_pkg;

   // register offsets
   localparam logic [11:0] DCM_OFS_PHASE = 12'h07f;
   localparam logic [11:0] DCM_OFS_DUTY  = 12'h082;
   localparam logic [11:0] DCM_OFS_SHUF  = 12'h151;
   localparam logic [11:0] DCM_OFS_MODE  = 12'h152;

   // field positions
   localparam int DCM_DUTY_DCC_BIT  = 7;
   localparam int DCM_DUTY_OFS_BIT  = 6;
   localparam int DCM_DUTY_SIGN_BIT = 4;
   localparam int DCM_PH_SIGN_BIT   = 5;
   localparam int DCM_SHUF_EN_BIT   = 2;
   localparam int DCM_SHUF_INTP_BIT = 0;

   // values after reset
   localparam logic [7:0]  DCM_RST_PHASE = 8'h00;
   localparam logic [7:0]  DCM_RST_DUTY  = 8'h00;
   localparam logic [1:0]  DCM_RST_MODE  = 2'h0;
   localparam logic [15:0] DCM_LFSR_SEED = 16'hace1;

   // mode codes
   localparam logic [1:0] DCM_CODE_HOLD = 2'b00;
   localparam logic [1:0] DCM_CODE_RZ   = 2'b10;
   localparam logic [1:0] DCM_CODE_MIX  = 2'b01;

   // data layout
   localparam int DCM_SMP_W  = 16;
   localparam int DCM_SEG_N  = 7;
   localparam int DCM_LSB_W  = 13;
   localparam int DCM_FIFO_D = 8;

   typedef enum logic [1:0] {DCM_MODE_HOLD, DCM_MODE_RZ, DCM_MODE_MIX} dcm_mode_e;

   typedef struct packed {
      logic       dcc_en;
      logic       dco_en;
      logic       dco_neg;
      logic [3:0] dco_mag;
      logic [4:0] cap_pos;
      logic [4:0] cap_neg;
   } dcm_trim_s;

   typedef struct packed {
      logic [DCM_SEG_N-1:0] therm;
      logic [DCM_LSB_W-1:0] lsb;
   } dcm_word_s;

endpackage

// [core/dcm_fifo.sv]
// small sample fifo with a registered output stage
`timescale 1ns/1ps
module dcm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // drain side
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [CW-1:0]    cnt_ff;
   logic [WIDTH-1:0] out_data_ff;
   logic             out_valid_ff;
   logic             push;
   logic             load;

   assign in_ready  = (cnt_ff < CW'(DEPTH));
   assign push      = in_valid && in_ready;
   // output stage refills only from stored words, so no read-during-write case exists
   assign load      = (cnt_ff != '0) && (!out_valid_ff || out_ready);
   assign out_data  = out_data_ff;
   assign out_valid = out_valid_ff;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (load) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !load) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (load && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_data_ff  <= '0;
         out_valid_ff <= 1'b0;
      end else if (load) begin
         out_data_ff  <= mem_ff[rd_ptr_ff];
         out_valid_ff <= 1'b1;
      end else if (out_ready) begin
         out_valid_ff <= 1'b0;
      end
   end
endmodule

// [core/dcm_core.sv]
// dac core mode sequencing, clock trim decode and msb segment shuffle
`timescale 1ns/1ps
module dcm_core #(
   parameter int FIFO_DEPTH = dcm_pkg::DCM_FIFO_D
) (
   // clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // configuration register port
   input  wire logic [11:0]                    reg_addr,
   input  wire logic [7:0]                     reg_wdata,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   output logic [7:0]                          reg_rdata,
   output logic                                reg_rvalid,
   // sample stream
   input  wire logic [dcm_pkg::DCM_SMP_W-1:0]  in_data,
   input  wire logic                           in_valid,
   output logic                                in_ready,
   // switch core side
   output dcm_pkg::dcm_word_s                  core_word,
   output logic [dcm_pkg::DCM_SMP_W-1:0]       core_sample,
   output logic                                pair_a_en,
   output logic                                pair_b_en,
   // clock trim and shuffle state
   output dcm_pkg::dcm_trim_s                  trim,
   output logic                                shuffle_on
);
   import dcm_pkg::*;

   logic [7:0]           phase_ff;
   logic [7:0]           duty_ff;
   logic                 shuf_en_ff;
   logic                 interp_en_ff;
   logic [1:0]           mode_bits_ff;
   logic [7:0]           reg_rdata_ff;
   logic                 reg_rvalid_ff;
   logic                 slot_ff;
   logic [DCM_SMP_W-1:0] ahead_ff;
   logic [DCM_SMP_W-1:0] shown_ff;
   logic [DCM_SMP_W-1:0] core_sample_ff;
   dcm_word_s            core_word_ff;
   logic                 out_slot_ff;
   dcm_mode_e            out_mode_ff;
   logic                 out_interp_ff;
   dcm_trim_s            trim_ff;
   logic [15:0]          lfsr_ff;

   logic [DCM_SMP_W-1:0] f_data;
   logic                 f_valid;
   logic                 f_ready;
   dcm_mode_e            mode_now;
   logic                 interp_eff;
   logic                 rise;
   logic [DCM_SMP_W-1:0] in_smp;
   logic [DCM_SMP_W-1:0] rise_smp;
   logic [DCM_SMP_W-1:0] slot_smp;
   logic [DCM_SEG_N-1:0] therm_raw;
   logic [DCM_SEG_N-1:0] therm_rot;
   logic [2:0]           rot;

   function automatic dcm_mode_e decode_mode(input logic [1:0] code);
      dcm_mode_e m;
      case (code)
         DCM_CODE_HOLD: m = DCM_MODE_HOLD;
         DCM_CODE_RZ:   m = DCM_MODE_RZ;
         DCM_CODE_MIX:  m = DCM_MODE_MIX;
         default:       m = DCM_MODE_HOLD;
      endcase
      return m;
   endfunction

   function automatic logic [1:0] mode_code(input dcm_mode_e m);
      logic [1:0] c;
      unique case (m)
         DCM_MODE_HOLD: c = DCM_CODE_HOLD;
         DCM_MODE_RZ:   c = DCM_CODE_RZ;
         DCM_MODE_MIX:  c = DCM_CODE_MIX;
      endcase
      return c;
   endfunction

   // two-tap midpoint: cheap, but gives far less image rejection than a real half-band
   function automatic logic [DCM_SMP_W-1:0] half_band_2x_filter(input logic [DCM_SMP_W-1:0] a,
                                                                 input logic [DCM_SMP_W-1:0] b);
      logic [DCM_SMP_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[DCM_SMP_W:1];
   endfunction

   // configuration registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff     <= DCM_RST_PHASE;
         duty_ff      <= DCM_RST_DUTY;
         shuf_en_ff   <= 1'b0;
         interp_en_ff <= 1'b0;
         mode_bits_ff <= DCM_RST_MODE;
      end else if (reg_wr) begin
         unique case (reg_addr)
            DCM_OFS_PHASE: phase_ff <= {2'b00, reg_wdata[5:0]};
            DCM_OFS_DUTY:  duty_ff  <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
            DCM_OFS_SHUF: begin
               shuf_en_ff   <= reg_wdata[DCM_SHUF_EN_BIT];
               interp_en_ff <= reg_wdata[DCM_SHUF_INTP_BIT];
            end
            DCM_OFS_MODE:  mode_bits_ff <= reg_wdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // readback, mode register also shows the mode actually applied
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff  <= 8'h00;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_rd;
         if (reg_rd) begin
            unique case (reg_addr)
               DCM_OFS_PHASE: reg_rdata_ff <= phase_ff;
               DCM_OFS_DUTY:  reg_rdata_ff <= duty_ff;
               DCM_OFS_SHUF:  reg_rdata_ff <= {5'b00000, shuf_en_ff, 1'b0, interp_en_ff};
               DCM_OFS_MODE:  reg_rdata_ff <= {4'h0, mode_code(mode_now), mode_bits_ff};
               default:       reg_rdata_ff <= 8'h00;
            endcase
         end
      end
   end

   assign reg_rdata  = reg_rdata_ff;
   assign reg_rvalid = reg_rvalid_ff;

   // trim decode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim_ff <= '0;
      end else begin
         trim_ff.dcc_en  <= duty_ff[DCM_DUTY_DCC_BIT];
         trim_ff.dco_en  <= duty_ff[DCM_DUTY_OFS_BIT];
         trim_ff.dco_neg <= duty_ff[DCM_DUTY_SIGN_BIT];
         trim_ff.dco_mag <= duty_ff[3:0];
         trim_ff.cap_pos <= phase_ff[DCM_PH_SIGN_BIT] ? 5'h00 : phase_ff[4:0];
         trim_ff.cap_neg <= phase_ff[DCM_PH_SIGN_BIT] ? phase_ff[4:0] : 5'h00;
      end
   end

   assign trim       = trim_ff;
   assign shuffle_on = shuf_en_ff;

   // sample source, one word taken per clock period on the rising slot
   dcm_fifo #(
      .WIDTH (DCM_SMP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (in_data),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_ready)
   );

   assign mode_now   = decode_mode(mode_bits_ff);
   assign interp_eff = interp_en_ff && (mode_now == DCM_MODE_HOLD);
   assign rise       = !slot_ff;
   assign f_ready    = rise;
   // an empty fifo repeats the last value rather than inject a spurious code
   assign in_smp     = f_valid ? f_data : (interp_eff ? ahead_ff : shown_ff);
   // filtering runs one sample behind to have the next sample for the midpoint
   assign rise_smp   = interp_eff ? ahead_ff : in_smp;

   always_comb begin
      slot_smp = rise_smp;
      if (!rise) begin
         unique case (mode_now)
            DCM_MODE_RZ:   slot_smp = '0;
            DCM_MODE_MIX:  slot_smp = ~shown_ff;
            DCM_MODE_HOLD: slot_smp = interp_eff ? half_band_2x_filter(shown_ff, ahead_ff)
                                                 : shown_ff;
         endcase
      end
   end

   // half-period slot, each clk cycle is one edge of the dac clock
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_ff <= 1'b0;
      end else begin
         slot_ff <= !slot_ff;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ahead_ff <= '0;
         shown_ff <= '0;
      end else if (rise) begin
         ahead_ff <= in_smp;
         shown_ff <= rise_smp;
      end
   end

   // shuffle: thermometer msb segments rotated by a pseudo random amount
   genvar gi;
   generate
      for (gi = 0; gi < DCM_SEG_N; gi++) begin : g_therm
         assign therm_raw[gi] = (slot_smp[DCM_SMP_W-1:DCM_LSB_W] > 3'(gi));
      end
   endgenerate

   assign rot       = (lfsr_ff[2:0] == 3'h7) ? 3'h0 : lfsr_ff[2:0];
   assign therm_rot = DCM_SEG_N'({therm_raw, therm_raw} >> rot);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lfsr_ff <= DCM_LFSR_SEED;
      end else begin
         lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
   end

   // switch core word, refreshed on every slot
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_sample_ff <= '0;
         core_word_ff   <= '0;
         out_slot_ff    <= 1'b1;
         out_mode_ff    <= DCM_MODE_HOLD;
         out_interp_ff  <= 1'b0;
      end else begin
         core_sample_ff     <= slot_smp;
         core_word_ff.therm <= shuf_en_ff ? therm_rot : therm_raw;
         core_word_ff.lsb   <= slot_smp[DCM_LSB_W-1:0];
         out_slot_ff        <= slot_ff;
         out_mode_ff        <= mode_now;
         out_interp_ff      <= interp_eff;
      end
   end

   assign core_sample = core_sample_ff;
   assign core_word   = core_word_ff;
   assign pair_a_en   = !out_slot_ff;
   assign pair_b_en   = out_slot_ff;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pair_alternate: assert property (pair_a_en |=> pair_b_en ##1 pair_a_en)
      else $error("switch pairs do not alternate");
   a_mode_rz_decode: assert property ($past(mode_bits_ff) == DCM_CODE_RZ |-> out_mode_ff == DCM_MODE_RZ)
      else $error("rz code not applied");
   a_mode_mix_decode: assert property ($past(mode_bits_ff) == DCM_CODE_MIX |-> out_mode_ff == DCM_MODE_MIX)
      else $error("mix code not applied");
   a_reserved_as_hold: assert property ($past(mode_bits_ff) == 2'b11 |-> out_mode_ff == DCM_MODE_HOLD)
      else $error("reserved mode not held");
   a_rz_fall_zero: assert property (pair_b_en && out_mode_ff == DCM_MODE_RZ |-> core_sample == '0)
      else $error("rz falling slot not zero");
   a_mix_fall_compl: assert property (pair_b_en && out_mode_ff == DCM_MODE_MIX && $past(out_mode_ff) == DCM_MODE_MIX
                                      |-> core_sample == ~$past(core_sample))
      else $error("mix falling slot not complement");
   a_hold_fall_same: assert property (pair_b_en && out_mode_ff == DCM_MODE_HOLD && !out_interp_ff
                                      && $past(out_mode_ff) == DCM_MODE_HOLD && !$past(out_interp_ff)
                                      |-> core_sample == $past(core_sample))
      else $error("hold falling slot changed");
   a_interp_mid_fall: assert property (pair_b_en && out_interp_ff && $past(out_interp_ff)
                                       |-> core_sample == half_band_2x_filter($past(core_sample), ahead_ff))
      else $error("filter midpoint wrong");
   a_rz_new_edge: assert property (pair_a_en && out_mode_ff == DCM_MODE_RZ && core_sample != '0
                                   ##1 out_mode_ff == DCM_MODE_RZ |-> core_sample != $past(core_sample))
      else $error("rz edge did not update");
   a_duty_write: assert property (reg_wr && reg_addr == DCM_OFS_DUTY ##1 !(reg_wr && reg_addr == DCM_OFS_DUTY)
                                  |=> trim.dcc_en == $past(reg_wdata[7], 2) && trim.dco_en == $past(reg_wdata[6], 2)
                                      && trim.dco_neg == $past(reg_wdata[4], 2)
                                      && trim.dco_mag == $past(reg_wdata[3:0], 2))
      else $error("duty trim not decoded");
   a_phase_one_side: assert property (trim.cap_pos == 5'h00 || trim.cap_neg == 5'h00)
      else $error("phase load on both inputs");
   a_phase_write: assert property (reg_wr && reg_addr == DCM_OFS_PHASE ##1 !(reg_wr && reg_addr == DCM_OFS_PHASE)
                                   |=> (trim.cap_pos | trim.cap_neg) == $past(reg_wdata[4:0], 2))
      else $error("phase magnitude lost");
   a_shuffle_lsb_fixed: assert property (core_word.lsb == core_sample[DCM_LSB_W-1:0]
                                         && $countones(core_word.therm) == int'(core_sample[15:13]))
      else $error("shuffle disturbed value");
   a_shuffle_off_plain: assert property (!$past(shuf_en_ff) |-> core_word.therm == DCM_SEG_N'(
                                         (8'h01 << core_sample[15:13]) - 8'h01))
      else $error("segments moved with shuffle off");

   c_rz_fall: cover property (pair_b_en && out_mode_ff == DCM_MODE_RZ && $past(core_sample) != '0);
   c_mix_fall: cover property (pair_b_en && out_mode_ff == DCM_MODE_MIX);
   c_interp_fall: cover property (pair_b_en && out_interp_ff && $past(out_interp_ff));
   c_shuffle_rot: cover property (shuffle_on && core_word.therm != DCM_SEG_N'((8'h01 << core_sample[15:13]) - 8'h01));
   c_fifo_full: cover property (in_valid && !in_ready);
endmodule

// [bench/dcm_switch_model.sv]
// behavioural switch core that latches the value shown in each half period
`timescale 1ns/1ps
module dcm_switch_model (
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // switch core drive
   input  wire logic [dcm_pkg::DCM_SMP_W-1:0] core_sample,
   input  wire logic                          pair_a_en,
   input  wire logic                          pair_b_en,
   // latched levels and slot sequencing flag
   output logic [dcm_pkg::DCM_SMP_W-1:0]      rise_q,
   output logic [dcm_pkg::DCM_SMP_W-1:0]      fall_q,
   output logic                               slot_bad
);
   import dcm_pkg::*;

   logic last_a_ff;
   logic started_ff;

   // pair a carries the rising slot, pair b the falling slot
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rise_q <= '0;
         fall_q <= '0;
      end else if (pair_a_en) begin
         rise_q <= core_sample;
      end else begin
         fall_q <= core_sample;
      end
   end

   // sticky: both pairs on, none on, or the same pair twice in a row
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_bad   <= 1'b0;
         last_a_ff  <= 1'b0;
         started_ff <= 1'b0;
      end else begin
         slot_bad   <= slot_bad | (pair_a_en !== ~pair_b_en) | (started_ff && pair_a_en === last_a_ff);
         last_a_ff  <= pair_a_en;
         started_ff <= 1'b1;
      end
   end
endmodule

// [bench/tb.sv]
// self-checking bench for the dac core mode, trim and shuffle control
`timescale 1ns/1ps
module tb;
   import dcm_pkg::*;

   logic                 clk;
   logic                 rst;
   logic [11:0]          reg_addr;
   logic [7:0]           reg_wdata;
   logic                 reg_wr;
   logic                 reg_rd;
   logic [7:0]           reg_rdata;
   logic                 reg_rvalid;
   logic [DCM_SMP_W-1:0] in_data;
   logic                 in_valid;
   logic                 in_ready;
   dcm_word_s            core_word;
   logic [DCM_SMP_W-1:0] core_sample;
   logic                 pair_a_en;
   logic                 pair_b_en;
   dcm_trim_s            trim;
   logic                 shuffle_on;
   logic [DCM_SMP_W-1:0] rise_q;
   logic [DCM_SMP_W-1:0] fall_q;
   logic                 slot_bad;
   logic [DCM_SMP_W-1:0] src_a;
   logic [DCM_SMP_W-1:0] src_b;
   logic [6:0]           therm_q;
   logic                 moved;
   int                   n_errors;
   int                   num_checks;

   dcm_core u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .in_data(in_data), .in_valid(in_valid),
      .in_ready(in_ready), .core_word(core_word), .core_sample(core_sample), .pair_a_en(pair_a_en),
      .pair_b_en(pair_b_en), .trim(trim), .shuffle_on(shuffle_on));

   dcm_switch_model u_core (.clk(clk), .rst(rst), .core_sample(core_sample), .pair_a_en(pair_a_en),
      .pair_b_en(pair_b_en), .rise_q(rise_q), .fall_q(fall_q), .slot_bad(slot_bad));

   always #10 clk = ~clk;

   // source alternates src_a and src_b, faster than the drain so the fifo fills
   always @(posedge clk) begin
      if (in_valid && in_ready) begin
         in_data <= (in_data == src_a) ? src_b : src_a;
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic check_read(input logic [11:0] a, input logic [7:0] exp);
      int i;
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      for (i = 0; i < 4; i++) begin
         #1;
         if (reg_rvalid === 1'b1) break;
         @(posedge clk);
      end
      if (i == 4) begin
         n_errors++;
         summarize();
      end
      chk(reg_rdata, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_ready(input logic lvl);
      int i;
      for (i = 0; i < 40 && in_ready !== lvl; i++) settle(1);
      chk(in_ready, lvl);
      // a stream that never reaches the level ends the run here
      if (in_ready !== lvl) summarize();
   endtask

   task automatic run_mode(input logic [1:0] code, input logic [15:0] s, input logic [15:0] f, input logic [7:0] rb);
      reg_write(DCM_OFS_MODE, {6'h00, code});
      src_a <= s;
      src_b <= s;
      // a full fifo of stale words needs up to 22 edges to drain through the slots
      settle(32);
      chk(rise_q, s);
      chk(fall_q, f);
      chk(slot_bad, 1'b0);
      check_read(DCM_OFS_MODE, rb);
   endtask

   task automatic run_phase(input logic [7:0] w, input logic [4:0] pos, input logic [4:0] neg, input logic [7:0] rb);
      reg_write(DCM_OFS_PHASE, w);
      settle(2);
      chk(trim.cap_pos, pos);
      chk(trim.cap_neg, neg);
      check_read(DCM_OFS_PHASE, rb);
   endtask

   task automatic watch_therm(input int n);
      therm_q = core_word.therm;
      moved   = 1'b0;
      repeat (n) begin
         settle(1);
         chk($countones(core_word.therm), 3);
         chk(core_word.lsb, 13'h0123);
         moved = moved | (core_word.therm !== therm_q);
      end
   endtask

   initial begin
      clk = 0; rst = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
      in_valid = 0; in_data = 0; src_a = 0; src_b = 0; n_errors = 0; num_checks = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // values after reset, unmapped place reads zero
      check_read(DCM_OFS_PHASE, 8'h00);
      check_read(DCM_OFS_DUTY, 8'h00);
      check_read(DCM_OFS_SHUF, 8'h00);
      chk({trim, shuffle_on}, 18'h0_0000);
      reg_write(12'h100, 8'hff);
      check_read(12'h100, 8'h00);
      $display("test reset_regs done");
      // fifo fills until refused, then drains when the source stops
      @(posedge clk);
      in_valid <= 1'b1;
      wait_ready(1'b0);
      @(posedge clk);
      in_valid <= 1'b0;
      wait_ready(1'b1);
      @(posedge clk);
      in_valid <= 1'b1;
      $display("test fifo done");
      // duty trim fields, reserved bit 5 reads back zero
      reg_write(DCM_OFS_DUTY, 8'hd5);
      settle(2);
      chk({trim.dcc_en, trim.dco_en}, 2'b11);
      chk({trim.dco_neg, trim.dco_mag}, 5'h15);
      reg_write(DCM_OFS_DUTY, 8'h2a);
      settle(2);
      chk({trim.dcc_en, trim.dco_en, trim.dco_neg, trim.dco_mag}, 7'h0a);
      check_read(DCM_OFS_DUTY, 8'h0a);
      $display("test duty done");
      run_phase(8'h25, 5'h00, 5'h05, 8'h25);
      run_phase(8'h1f, 5'h1f, 5'h00, 8'h1f);
      run_phase(8'h20, 5'h00, 5'h00, 8'h20);
      run_phase(8'hff, 5'h00, 5'h1f, 8'h3f);
      $display("test phase done");
      run_mode(2'b00, 16'h8a5c, 16'h8a5c, 8'h00);
      run_mode(2'b10, 16'h8a5c, 16'h0000, 8'h0a);
      run_mode(2'b01, 16'h8a5c, 16'h75a3, 8'h05);
      run_mode(2'b11, 16'h8a5c, 16'h8a5c, 8'h03);
      $display("test modes done");
      // filter in hold mode: falling slot is the midpoint of neighbours
      reg_write(DCM_OFS_MODE, 8'h00);
      reg_write(DCM_OFS_SHUF, 8'h01);
      src_a <= 16'h1000;
      src_b <= 16'h3000;
      settle(32);
      chk(fall_q, 16'h2000);
      $display("test filter done");
      // shuffle: msb segments move, count of lit segments and low bits fixed
      reg_write(DCM_OFS_SHUF, 8'h04);
      src_a <= 16'h6123;
      src_b <= 16'h6123;
      settle(32);
      chk(shuffle_on, 1'b1);
      watch_therm(16);
      chk(moved, 1'b1);
      check_read(DCM_OFS_SHUF, 8'h04);
      reg_write(DCM_OFS_SHUF, 8'h00);
      settle(4);
      chk(shuffle_on, 1'b0);
      watch_therm(8);
      chk(moved, 1'b0);
      chk(core_word.therm, 7'h07);
      $display("test shuffle done");
      summarize();
   end
endmodule
